// File: logic/cmp_ref_delay_pkg.sv
// Shared constants and types for the comparator reference and pulse-delay control block.
package cmp_ref_delay_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;

    // Word addresses of the registers.
    localparam logic [2:0] ADDR_REF_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_MEAS_FIRST = 3'h1;
    localparam logic [2:0] ADDR_MEAS_SECND = 3'h2;
    localparam logic [2:0] ADDR_MEAS_CURR  = 3'h3;
    localparam logic [2:0] ADDR_STATUS     = 3'h4;

    localparam logic [7:0]  REF_CTRL_RESET   = 8'h00;
    localparam logic [15:0] MEAS_FIRST_RESET = 16'h0000;
    localparam logic [15:0] MEAS_SECND_RESET = 16'h0000;
    localparam logic [7:0]  MEAS_CURR_RESET  = 8'h00;

    // Bit positions in the first measurement control register.
    localparam int BIT_MODULE_EN    = 15;
    localparam int BIT_STOP_IDLE    = 13;
    localparam int BIT_DELAY_GEN    = 12;
    localparam int BIT_EDGE_PASS    = 11;
    localparam int BIT_EDGE_ORDER   = 10;
    localparam int BIT_DISCHARGE    = 9;
    localparam int BIT_TRIG_OUT     = 8;
    localparam logic [15:0] MEAS_FIRST_MASK = 16'hBF00;

    // Edge configuration fields in the second register: edge 1 high byte, edge 2 low byte.
    localparam int EDGE1_LSB = 9;
    localparam int EDGE2_LSB = 1;
    localparam logic [15:0] MEAS_SECND_MASK = 16'hFEFE;

    // Status bits.
    localparam int ST_EDGE1 = 0;
    localparam int ST_EDGE2 = 1;
    localparam int ST_CHARGING = 2;
    localparam int ST_DISCHARGE = 3;

    // Edge source codes: 0..12 external pins, 13..15 comparators 1..3, 16..19 internal sources.
    localparam int N_EXT = 13;
    localparam int N_CMP = 3;
    localparam int N_INT = 4;
    localparam int N_SRC = N_EXT + N_CMP + N_INT;
    localparam logic [4:0] SEL_CMP2 = 5'h0E;

    typedef struct packed {
        logic       ladder_power_on;
        logic       ref_pin_drive;
        logic       ref_source_sel;
        logic [4:0] ref_level_code;
    } ref_ctrl_type;

    typedef struct packed {
        logic       edge_mode;
        logic       edge_pol;
        logic [4:0] edge_sel;
        logic       spare;
    } edge_cfg_type;

    typedef enum logic [1:0] {
        SEQ_IDLE     = 2'b00,
        SEQ_CHARGING = 2'b01,
        SEQ_DONE     = 2'b10
    } seq_state_type;

endpackage

// File: logic/cmp_reference_and_pulse_delay_ctrl.sv
// Register bank and edge sequencer for the comparator reference ladder and pulse-delay unit.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
module cmp_reference_and_pulse_delay_ctrl (
    input  wire logic                                     MCLK,
    input  wire logic                                     RSTN,
    input  wire logic [cmp_ref_delay_pkg::ADDR_W-1:0]     AVS_ADDRESS,
    input  wire logic                                     AVS_READ,
    input  wire logic                                     AVS_WRITE,
    input  wire logic [cmp_ref_delay_pkg::DATA_W-1:0]     AVS_WRITEDATA,
    input  wire logic [3:0]                               AVS_BYTEENABLE,
    output logic      [cmp_ref_delay_pkg::DATA_W-1:0]     AVS_READDATA,
    output logic                                          AVS_WAITREQUEST,
    input  wire logic [cmp_ref_delay_pkg::N_EXT-1:0]      EXT_EDGE_INPUT,
    input  wire logic [cmp_ref_delay_pkg::N_CMP-1:0]      CMP_OUT,
    input  wire logic [cmp_ref_delay_pkg::N_INT-1:0]      INT_EDGE_SRC,
    output logic                                          LADDER_POWER_ON,
    output logic                                          REF_PIN_DRIVE,
    output logic                                          REF_SOURCE_SEL,
    output logic      [4:0]                               REF_LEVEL_CODE,
    output logic                                          CUR_TO_CMP2_B_IN,
    output logic                                          CUR_SRC_CHARGE,
    output logic                                          CUR_SRC_GROUND,
    output logic                                          DELAY_PULSE_OUT,
    output logic                                          MEAS_PULSE_OUT,
    output logic                                          TRIG_OUT,
    output logic      [1:0]                               CUR_RANGE,
    output logic      [5:0]                               CUR_TRIM
);

    localparam int NS = cmp_ref_delay_pkg::N_SRC;

    // Edge event for one configured channel: level mode fires while the level is active.
    function automatic logic edge_hit(input logic [NS-1:0] cur,
                                      input logic [NS-1:0] prev,
                                      input cmp_ref_delay_pkg::edge_cfg_type cfg);
        logic now_lvl;
        logic old_lvl;
        now_lvl = 1'b0;
        old_lvl = 1'b0;
        if (int'(cfg.edge_sel) < NS) begin
            now_lvl = cur[cfg.edge_sel] ~^ cfg.edge_pol;
            old_lvl = prev[cfg.edge_sel] ~^ cfg.edge_pol;
        end
        edge_hit = cfg.edge_mode ? (now_lvl & ~old_lvl) : now_lvl;
    endfunction

    // Register group.
    cmp_ref_delay_pkg::ref_ctrl_type ref_ctrl;
    cmp_ref_delay_pkg::ref_ctrl_type next_ref_ctrl;
    logic [15:0]                     meas_first;
    logic [15:0]                     next_meas_first;
    logic [15:0]                     meas_secnd;
    logic [15:0]                     next_meas_secnd;
    logic [7:0]                      meas_curr;
    logic [7:0]                      next_meas_curr;

    // Bus group.
    logic [cmp_ref_delay_pkg::DATA_W-1:0] next_readdata;
    logic                                 next_waitrequest;
    logic                                 access;
    logic                                 wr_access;

    // Input synchroniser group.
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    logic [NS-1:0] src_prev;

    // Sequencer group.
    cmp_ref_delay_pkg::seq_state_type seq;
    cmp_ref_delay_pkg::seq_state_type next_seq;
    logic                             edge1_seen;
    logic                             next_edge1_seen;
    logic                             edge2_seen;
    logic                             next_edge2_seen;
    logic                             auto_ground;
    logic                             next_auto_ground;

    // Output group.
    logic next_cur_to_cmp2;
    logic next_charge;
    logic next_ground;
    logic next_delay_pulse;
    logic next_meas_pulse;
    logic next_trig;

    cmp_ref_delay_pkg::edge_cfg_type edge1_cfg;
    cmp_ref_delay_pkg::edge_cfg_type edge2_cfg;
    logic module_en;
    logic delay_mode;
    logic edge1_ev;
    logic edge2_ev;
    logic stop_ev;

    assign access    = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
    assign wr_access = AVS_WRITE & ~AVS_WAITREQUEST;
    assign edge1_cfg = meas_secnd[cmp_ref_delay_pkg::EDGE1_LSB-1 +: 8];
    assign edge2_cfg = meas_secnd[cmp_ref_delay_pkg::EDGE2_LSB-1 +: 8];
    assign module_en = meas_first[cmp_ref_delay_pkg::BIT_MODULE_EN];
    assign delay_mode = module_en & meas_first[cmp_ref_delay_pkg::BIT_DELAY_GEN];

    // Registers: writes land on the edge where waitrequest is sampled low.
    always_comb begin
        next_ref_ctrl   = ref_ctrl;
        next_meas_first = meas_first;
        next_meas_secnd = meas_secnd;
        next_meas_curr  = meas_curr;
        if (wr_access && AVS_BYTEENABLE[0]) begin
            unique case (AVS_ADDRESS)
                cmp_ref_delay_pkg::ADDR_REF_CTRL: begin
                    next_ref_ctrl = AVS_WRITEDATA[7:0];
                end
                cmp_ref_delay_pkg::ADDR_MEAS_SECND: begin
                    next_meas_secnd[7:0] = AVS_WRITEDATA[7:0]
                                           & cmp_ref_delay_pkg::MEAS_SECND_MASK[7:0];
                end
                cmp_ref_delay_pkg::ADDR_MEAS_CURR: begin
                    next_meas_curr = AVS_WRITEDATA[7:0];
                end
                default: begin
                end
            endcase
        end
        // The byte above bit 7 of the reference register is never stored.
        if (wr_access && AVS_BYTEENABLE[1]) begin
            unique case (AVS_ADDRESS)
                cmp_ref_delay_pkg::ADDR_MEAS_FIRST: begin
                    next_meas_first[15:8] = AVS_WRITEDATA[15:8]
                                            & cmp_ref_delay_pkg::MEAS_FIRST_MASK[15:8];
                end
                cmp_ref_delay_pkg::ADDR_MEAS_SECND: begin
                    next_meas_secnd[15:8] = AVS_WRITEDATA[15:8]
                                            & cmp_ref_delay_pkg::MEAS_SECND_MASK[15:8];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_ctrl   <= cmp_ref_delay_pkg::REF_CTRL_RESET;
            meas_first <= cmp_ref_delay_pkg::MEAS_FIRST_RESET;
            meas_secnd <= cmp_ref_delay_pkg::MEAS_SECND_RESET;
            meas_curr  <= cmp_ref_delay_pkg::MEAS_CURR_RESET;
        end else begin
            ref_ctrl   <= next_ref_ctrl;
            meas_first <= next_meas_first;
            meas_secnd <= next_meas_secnd;
            meas_curr  <= next_meas_curr;
        end
    end

    // Bus slave: one wait cycle per access, then data and a single low waitrequest.
    always_comb begin
        next_readdata    = AVS_READDATA;
        next_waitrequest = 1'b1;
        if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
            next_waitrequest = 1'b0;
            next_readdata    = '0;
            if (AVS_READ) begin
                unique case (AVS_ADDRESS)
                    cmp_ref_delay_pkg::ADDR_REF_CTRL: begin
                        next_readdata[7:0] = ref_ctrl;
                    end
                    cmp_ref_delay_pkg::ADDR_MEAS_FIRST: begin
                        next_readdata[15:0] = meas_first;
                    end
                    cmp_ref_delay_pkg::ADDR_MEAS_SECND: begin
                        next_readdata[15:0] = meas_secnd;
                    end
                    cmp_ref_delay_pkg::ADDR_MEAS_CURR: begin
                        next_readdata[7:0] = meas_curr;
                    end
                    cmp_ref_delay_pkg::ADDR_STATUS: begin
                        next_readdata[cmp_ref_delay_pkg::ST_EDGE1]     = edge1_seen;
                        next_readdata[cmp_ref_delay_pkg::ST_EDGE2]     = edge2_seen;
                        next_readdata[cmp_ref_delay_pkg::ST_CHARGING]  = CUR_SRC_CHARGE;
                        next_readdata[cmp_ref_delay_pkg::ST_DISCHARGE] = CUR_SRC_GROUND;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            AVS_READDATA    <= '0;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_READDATA    <= next_readdata;
            AVS_WAITREQUEST <= next_waitrequest;
        end
    end

    // Pins and comparator outputs are asynchronous; only sync_b and later are read.
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            sync_a   <= '0;
            sync_b   <= '0;
            src_prev <= '0;
        end else begin
            sync_a   <= {INT_EDGE_SRC, CMP_OUT, EXT_EDGE_INPUT};
            sync_b   <= sync_a;
            src_prev <= sync_b;
        end
    end

    // Edges reach the sequencer only with the module on and edges unblocked.
    always_comb begin
        edge1_ev = module_en && meas_first[cmp_ref_delay_pkg::BIT_EDGE_PASS]
                   && edge_hit(sync_b, src_prev, edge1_cfg);
        edge2_ev = module_en && meas_first[cmp_ref_delay_pkg::BIT_EDGE_PASS]
                   && edge_hit(sync_b, src_prev, edge2_cfg);
        if (meas_first[cmp_ref_delay_pkg::BIT_EDGE_ORDER] && !edge1_seen && !edge1_ev) begin
            edge2_ev = 1'b0;
        end
        // In delay mode the stop is the comparator 2 trip chosen as edge 2.
        stop_ev = edge2_ev && (!delay_mode
                               || edge2_cfg.edge_sel == cmp_ref_delay_pkg::SEL_CMP2);
    end

    // Sequencer. The two edge status bits are cleared by writing zero; a same-cycle hardware set wins.
    always_comb begin
        next_seq         = seq;
        next_edge1_seen  = edge1_seen;
        next_edge2_seen  = edge2_seen;
        next_auto_ground = auto_ground;
        if (wr_access && AVS_BYTEENABLE[0] && AVS_ADDRESS == cmp_ref_delay_pkg::ADDR_STATUS) begin
            next_edge1_seen = edge1_seen & AVS_WRITEDATA[cmp_ref_delay_pkg::ST_EDGE1];
            next_edge2_seen = edge2_seen & AVS_WRITEDATA[cmp_ref_delay_pkg::ST_EDGE2];
            if (!next_edge1_seen && !next_edge2_seen) begin
                next_seq = cmp_ref_delay_pkg::SEQ_IDLE;
            end
        end
        unique case (seq)
            cmp_ref_delay_pkg::SEQ_IDLE: begin
                next_edge2_seen = next_edge2_seen | (edge2_ev & ~edge1_ev);
                if (edge1_ev) begin
                    next_edge1_seen  = 1'b1;
                    next_auto_ground = 1'b0;
                    next_seq         = cmp_ref_delay_pkg::SEQ_CHARGING;
                end
            end
            cmp_ref_delay_pkg::SEQ_CHARGING: begin
                if (stop_ev) begin
                    next_edge2_seen  = 1'b1;
                    next_auto_ground = delay_mode;
                    next_seq         = cmp_ref_delay_pkg::SEQ_DONE;
                end
            end
            cmp_ref_delay_pkg::SEQ_DONE: begin
                // Delay mode rearms on the next start edge without software help.
                if (delay_mode && edge1_ev) begin
                    next_edge1_seen  = 1'b1;
                    next_edge2_seen  = 1'b0;
                    next_auto_ground = 1'b0;
                    next_seq         = cmp_ref_delay_pkg::SEQ_CHARGING;
                end
            end
            default: begin
                next_seq = cmp_ref_delay_pkg::SEQ_IDLE;
            end
        endcase
        if (!module_en) begin
            next_seq         = cmp_ref_delay_pkg::SEQ_IDLE;
            next_auto_ground = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            seq         <= cmp_ref_delay_pkg::SEQ_IDLE;
            edge1_seen  <= 1'b0;
            edge2_seen  <= 1'b0;
            auto_ground <= 1'b0;
        end else begin
            seq         <= next_seq;
            edge1_seen  <= next_edge1_seen;
            edge2_seen  <= next_edge2_seen;
            auto_ground <= next_auto_ground;
        end
    end

    // The pulse width is set by the analog trip; the clock only quantises it to one period.
    always_comb begin
        next_cur_to_cmp2 = delay_mode;
        next_charge      = (next_seq == cmp_ref_delay_pkg::SEQ_CHARGING);
        next_ground      = meas_first[cmp_ref_delay_pkg::BIT_DISCHARGE] | next_auto_ground;
        next_delay_pulse = delay_mode && next_charge;
        next_meas_pulse  = !delay_mode && next_charge;
        next_trig        = module_en && meas_first[cmp_ref_delay_pkg::BIT_TRIG_OUT] && next_charge;
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            CUR_TO_CMP2_B_IN <= 1'b0;
            CUR_SRC_CHARGE   <= 1'b0;
            CUR_SRC_GROUND   <= 1'b0;
            DELAY_PULSE_OUT  <= 1'b0;
            MEAS_PULSE_OUT   <= 1'b0;
            TRIG_OUT         <= 1'b0;
        end else begin
            CUR_TO_CMP2_B_IN <= next_cur_to_cmp2;
            CUR_SRC_CHARGE   <= next_charge;
            CUR_SRC_GROUND   <= next_ground;
            DELAY_PULSE_OUT  <= next_delay_pulse;
            MEAS_PULSE_OUT   <= next_meas_pulse;
            TRIG_OUT         <= next_trig;
        end
    end

    // Software must allow the ladder to settle after changing these.
    assign LADDER_POWER_ON = ref_ctrl.ladder_power_on;
    assign REF_PIN_DRIVE   = ref_ctrl.ref_pin_drive;
    assign REF_SOURCE_SEL  = ref_ctrl.ref_source_sel;
    assign REF_LEVEL_CODE  = ref_ctrl.ref_level_code;
    assign CUR_RANGE       = meas_curr[1:0];
    assign CUR_TRIM        = meas_curr[7:2];

endmodule

// File: bench/cmp_ref_delay_checker.sv
// Concurrent checks on the ports of the reference and pulse-delay control block.
module cmp_ref_delay_checker (
    input wire logic        MCLK,
    input wire logic        RSTN,
    input wire logic [2:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        LADDER_POWER_ON,
    input wire logic        REF_PIN_DRIVE,
    input wire logic        REF_SOURCE_SEL,
    input wire logic [4:0]  REF_LEVEL_CODE,
    input wire logic        CUR_TO_CMP2_B_IN,
    input wire logic        CUR_SRC_CHARGE,
    input wire logic        CUR_SRC_GROUND,
    input wire logic        DELAY_PULSE_OUT
);
    logic       ref_take;
    logic [7:0] ref_out;
    // Lane 0 alone carries the implemented bits, so only it counts as a reference write.
    assign ref_take = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 3'h0 && AVS_BYTEENABLE[0];
    assign ref_out = {LADDER_POWER_ON, REF_PIN_DRIVE, REF_SOURCE_SEL, REF_LEVEL_CODE};
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence bus_req;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence ref_wr;
        ref_take;
    endsequence
    AST_WAIT_ONE: assert property (bus_req |=> !AVS_WAITREQUEST)
        else $error("waitrequest did not drop one cycle after a request");
    AST_WAIT_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest stayed low for more than one cycle");
    AST_REF_LEVEL: assert property (ref_wr |=> REF_LEVEL_CODE == $past(AVS_WRITEDATA[4:0]))
        else $error("level code does not follow the written value");
    AST_REF_SRC: assert property (ref_wr |=> REF_SOURCE_SEL == $past(AVS_WRITEDATA[5]))
        else $error("source select does not follow the written value");
    AST_REF_PWR: assert property (ref_wr |=> LADDER_POWER_ON == $past(AVS_WRITEDATA[7]))
        else $error("ladder power does not follow the written value");
    AST_REF_PIN: assert property (ref_wr |=> REF_PIN_DRIVE == $past(AVS_WRITEDATA[6]))
        else $error("pin drive does not follow the written value");
    AST_REF_KEEP: assert property (!ref_take |=> $stable(ref_out))
        else $error("reference outputs changed without a write");
    AST_REF_RD: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 3'h0
        |-> AVS_READDATA == {24'h000000, ref_out})
        else $error("reference readback differs from outputs or upper bits set");
    AST_ROUTE: assert property (DELAY_PULSE_OUT |-> CUR_TO_CMP2_B_IN && CUR_SRC_CHARGE)
        else $error("delay pulse high without charge current routed");
    AST_GROUND: assert property ($fell(DELAY_PULSE_OUT) |-> CUR_SRC_GROUND && !CUR_SRC_CHARGE)
        else $error("current source not grounded at the stop edge");
    cover property ($rose(DELAY_PULSE_OUT));
endmodule

bind cmp_reference_and_pulse_delay_ctrl cmp_ref_delay_checker chk_u (
    .MCLK(MCLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .LADDER_POWER_ON(LADDER_POWER_ON), .REF_PIN_DRIVE(REF_PIN_DRIVE),
    .REF_SOURCE_SEL(REF_SOURCE_SEL), .REF_LEVEL_CODE(REF_LEVEL_CODE),
    .CUR_TO_CMP2_B_IN(CUR_TO_CMP2_B_IN), .CUR_SRC_CHARGE(CUR_SRC_CHARGE),
    .CUR_SRC_GROUND(CUR_SRC_GROUND), .DELAY_PULSE_OUT(DELAY_PULSE_OUT)
);

// File: bench/tb_top.sv
// Register-level testbench for the reference and pulse-delay control block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rstn, rd, wr, waitreq;
    logic [2:0]  addr, cmp_out;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  be, int_src;
    logic [12:0] ext_in;
    logic        lad_on, pin_drv, src_sel, to_b, charge, ground, dpulse, mpulse, trig;
    logic [4:0]  level;
    logic [1:0]  crange;
    logic [5:0]  ctrim;
    logic [31:0] vals [4] = '{32'hFFFFFFFF, 32'h000000A5, 32'h0000005A, 32'h0000C31F};
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          i;

    cmp_reference_and_pulse_delay_ctrl dut_u (
        .MCLK(mclk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .EXT_EDGE_INPUT(ext_in), .CMP_OUT(cmp_out),
        .INT_EDGE_SRC(int_src), .LADDER_POWER_ON(lad_on), .REF_PIN_DRIVE(pin_drv),
        .REF_SOURCE_SEL(src_sel), .REF_LEVEL_CODE(level), .CUR_TO_CMP2_B_IN(to_b),
        .CUR_SRC_CHARGE(charge), .CUR_SRC_GROUND(ground), .DELAY_PULSE_OUT(dpulse),
        .MEAS_PULSE_OUT(mpulse), .TRIG_OUT(trig), .CUR_RANGE(crange), .CUR_TRIM(ctrim)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The request is held until waitrequest is sampled low; data is taken at that edge.
    task bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge mclk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        @(posedge mclk);
        while (waitreq !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        check("bus answer", {31'h0, waitreq}, 32'h0);
        if (n >= 20) complete_run();
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task rd_chk(input string nm, input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        check(nm, rv, exp);
    endtask

    // Index 0 is the charge current, 1 the delay pulse, 2 the measurement pulse.
    task wait_on(input string nm, input int k, input logic v);
        logic [2:0] s;
        int n;
        for (n = 0; n < 40; n++) begin
            s = {mpulse, dpulse, charge};
            if (s[k] === v) break;
            @(posedge mclk);
        end
        check(nm, {31'h0, s[k]}, {31'h0, v});
        if (n == 40) complete_run();
    endtask

    task quiet(input string nm, input int k);
        logic [2:0] s;
        int n;
        for (n = 0; n < 12; n++) begin
            @(negedge mclk);
            s = {mpulse, dpulse, charge};
            if (s[k] !== 1'b0) break;
        end
        check(nm, {31'h0, s[k]}, 32'h0);
    endtask

    initial begin
        rstn = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 3'h0;
        wdata = 32'h0;
        be = 4'h0;
        ext_in = 13'h0000;
        cmp_out = 3'h0;
        int_src = 4'h0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        check("ref outputs", {24'h0, lad_on, pin_drv, src_sel, level}, 32'h0);
        for (i = 0; i < 5; i++) rd_chk("reset read", i[2:0], 32'h0);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 3'h0, vals[i], 4'hF);
            rd_chk("ref ctrl", 3'h0, vals[i] & 32'hFF);
            @(negedge mclk);
            check("ref pins", {24'h0, lad_on, pin_drv, src_sel, level},
                  vals[i] & 32'hFF);
        end
        bus(1'b1, 3'h0, 32'h0, 4'h2);
        rd_chk("ref upper lane", 3'h0, 32'h1F);
        bus(1'b1, 3'h5, 32'hFFFFFFFF, 4'hF);
        for (i = 5; i < 8; i++) rd_chk("unmapped", i[2:0], 32'h0);
        $display("test reference register done");
        bus(1'b1, 3'h3, 32'h0000FFB6, 4'hF);
        rd_chk("current reg", 3'h3, 32'hB6);
        @(negedge mclk);
        check("current fields", {24'h0, ctrim, crange}, 32'hB6);
        $display("test current register done");
        bus(1'b1, 3'h2, 32'h0000C0DC, 4'hF);
        bus(1'b1, 3'h1, 32'h00009000, 4'hF);
        @(posedge mclk) ext_in[0] <= 1'b1;
        quiet("blocked charge", 0);
        @(posedge mclk) ext_in[0] <= 1'b0;
        repeat (6) @(posedge mclk);
        $display("test edge block done");
        bus(1'b1, 3'h1, 32'h00009900, 4'hF);
        @(posedge mclk) ext_in[0] <= 1'b1;
        wait_on("delay start", 1, 1'b1);
        @(negedge mclk);
        check("charge route", {28'h0, to_b, charge, trig, mpulse}, 32'hE);
        @(posedge mclk) cmp_out[1] <= 1'b1;
        wait_on("delay stop", 1, 1'b0);
        @(negedge mclk);
        check("auto ground", {30'h0, ground, charge}, 32'h2);
        rd_chk("delay status", 3'h4, 32'hB);
        @(posedge mclk) ext_in[0] <= 1'b0;
        @(posedge mclk) cmp_out[1] <= 1'b0;
        repeat (6) @(posedge mclk);
        ext_in[0] <= 1'b1;
        wait_on("delay restart", 1, 1'b1);
        @(negedge mclk);
        check("ground released", {31'h0, ground}, 32'h0);
        @(posedge mclk) cmp_out[1] <= 1'b1;
        wait_on("second stop", 1, 1'b0);
        $display("test pulse delay done");
        bus(1'b1, 3'h1, 32'h00008C00, 4'hF);
        bus(1'b1, 3'h2, 32'h0000E0DC, 4'hF);
        @(posedge mclk) cmp_out[1] <= 1'b0;
        repeat (6) @(posedge mclk);
        bus(1'b1, 3'h4, 32'h0, 4'hF);
        @(posedge mclk) cmp_out[1] <= 1'b1;
        quiet("early edge2", 2);
        // The current source is still grounded from the last delay stop.
        rd_chk("early edge2 status", 3'h4, 32'h8);
        @(posedge mclk) cmp_out[1] <= 1'b0;
        repeat (6) @(posedge mclk);
        int_src[0] <= 1'b1;
        wait_on("measure start", 2, 1'b1);
        @(posedge mclk) cmp_out[1] <= 1'b1;
        wait_on("measure stop", 2, 1'b0);
        bus(1'b0, 3'h4, 32'h0, 4'hF);
        check("measure status", rv & 32'h3, 32'h3);
        $display("test measurement done");
        bus(1'b1, 3'h1, 32'h00008800, 4'hF);
        bus(1'b1, 3'h4, 32'h0, 4'hF);
        @(posedge mclk) cmp_out[1] <= 1'b0;
        repeat (6) @(posedge mclk);
        cmp_out[1] <= 1'b1;
        repeat (6) @(posedge mclk);
        rd_chk("free edge2 status", 3'h4, 32'h2);
        $display("test free edge order done");
        bus(1'b1, 3'h2, 32'h000042DC, 4'hF);
        bus(1'b1, 3'h4, 32'h0, 4'hF);
        quiet("level polarity", 2);
        bus(1'b1, 3'h2, 32'h000002DC, 4'hF);
        wait_on("level start", 2, 1'b1);
        $display("test level response done");
        @(posedge mclk) rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk("ref after reset", 3'h0, 32'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule
